//--- dpm_pkg.sv
// What the dual-port memory and its host must do
// [R1] Memory holds 64K or 128K words of 8 or 9 bits, all reachable.
// [R2] Each port reads or writes independently with own select, strobe, enable.
// [R3] Write happens while select and write strobe are both low.
// [R4] Cross-port read of freshly written word valid only after flow delay.
// [R5] Host asserts select and output enable together to read memory.
// [R6] Token latch read uses token latch select plus output enable.
// [R7] Highest address is the right port's mailbox.
// [R8] Second-highest address is the left port's mailbox.
// [R9] Writing the opposite mailbox raises the opposite port's interrupt.
// [R10] Reading own mailbox clears own interrupt.
// [R11] Reading the opposite mailbox leaves its interrupt unchanged.
// [R12] Contention flag active blocks setting the other port's interrupt.
// [R13] Contention flag active blocks clearing own interrupt.
// [R14] Simultaneous matching requests: exactly one port granted.
// [R15] Requests within priority window still grant one, winner unspecified.
// [R16] Loser's contention flag falls after address match or select low.
// [R17] Role pin high makes master outputs; low makes slave inputs.
// [R18] Master flags feed slave flag inputs directly.
// [R19] Host delays slave writes until contention flag input has settled.
// [R20] Port powers down, data lines released, while select is high.
// [R21] Host never asserts port select and token latch select together.
// [R22] Slave write inhibited while its contention flag input is low.
package dpm_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 9;
   localparam logic [ADDR_W-1:0] MBOX_RIGHT = 17'h1ffff;
   localparam logic [ADDR_W-1:0] MBOX_LEFT = 17'h1fffe;
   localparam int CLK_NS = 10;
   // Timing figures in ns
   localparam int T_WRITE_NS = 22;
   localparam int T_SETUP_NS = 5;
   localparam int T_ACCESS_NS = 25;
   localparam int T_FLOW_NS = 35;
   localparam int T_FLAG_NS = 20;
   localparam int T_RECOVER_NS = 10;
   // Least times rounded up
   localparam int WRITE_CYC = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int FLOW_CYC = (T_FLOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int FLAG_CYC = (T_FLAG_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 4;
   typedef enum logic [1:0] {DPM_OP_READ, DPM_OP_WRITE, DPM_OP_TOKEN_RD, DPM_OP_TOKEN_WR}
      dpm_op_t;
endpackage

//--- dpm_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Down counter that times each phase of a pin cycle
module dpm_timer (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [dpm_pkg::CNT_W-1:0] load_val,
   output logic done
);
   import dpm_pkg::*;
   logic [CNT_W-1:0] cnt_r;

   // Load wins over counting
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= '0;
      end else if (load) begin
         cnt_r <= load_val;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end

   // Done looks at the count only; gating it with load would loop back through the sequencer
   assign done = (cnt_r == '0);
endmodule
`default_nettype wire

//--- dpm_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host controller for one port of the dual-port memory
module dpm_host (
   input wire logic clk_sys,
   input wire logic reset_n,
   // User request side
   input wire logic req_valid,
   output logic req_ready,
   input wire dpm_pkg::dpm_op_t req_op,
   input wire logic [dpm_pkg::ADDR_W-1:0] req_addr,
   input wire logic [dpm_pkg::DATA_W-1:0] req_wdata,
   input wire logic slave_mode,
   output logic rsp_valid,
   output logic [dpm_pkg::DATA_W-1:0] rsp_rdata,
   output logic irq_pending,
   // Device pins of this port
   output logic port_sel_n,
   output logic token_latch_select_n,
   output logic write_n,
   output logic out_en_n,
   output logic [dpm_pkg::ADDR_W-1:0] addr,
   input wire logic [dpm_pkg::DATA_W-1:0] data_in,
   output logic [dpm_pkg::DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic contention_n,
   input wire logic mailbox_irq_n
);
   import dpm_pkg::*;

   typedef enum {ST_IDLE, ST_SETUP, ST_SETTLE, ST_STROBE, ST_RECOVER} dpm_state_t;
   dpm_state_t state_r;
   dpm_op_t op_r;
   logic [1:0] busy_sync_r;
   logic [1:0] irq_sync_r;
   logic [DATA_W-1:0] rd_data_r;
   logic rsp_valid_r;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_val;
   logic tmr_done;
   logic is_write;
   logic busy_now;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n);
   endfunction

   // Pin levels pass two flops before use
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busy_sync_r <= 2'h3;
         irq_sync_r <= 2'h3;
      end else begin
         busy_sync_r <= {busy_sync_r[0], contention_n};
         irq_sync_r <= {irq_sync_r[0], mailbox_irq_n};
      end
   end
   assign busy_now = !busy_sync_r[1];
   assign irq_pending = !irq_sync_r[1];

   assign is_write = (op_r == DPM_OP_WRITE) || (op_r == DPM_OP_TOKEN_WR);
   assign req_ready = (state_r == ST_IDLE);

   // Phase sequencing; timer restarts on entry to setup, settle, strobe and recover
   always_comb begin
      tmr_load = 1'b0;
      tmr_val = '0;
      case (state_r)
         ST_IDLE: begin
            if (req_valid) begin
               tmr_load = 1'b1;
               tmr_val = cyc(SETUP_CYC);
            end
         end
         ST_SETUP: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_val = cyc(FLAG_CYC); // Let a slave flag input settle [R19]
            end
         end
         ST_SETTLE: begin
            if (tmr_done && !(slave_mode && busy_now && is_write)) begin
               tmr_load = 1'b1;
               tmr_val = is_write ? cyc(WRITE_CYC) : cyc(ACCESS_CYC + FLOW_CYC); // [R4]
            end
         end
         ST_STROBE: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_val = cyc(RECOVER_CYC);
            end
         end
         default: begin
            tmr_load = 1'b0;
         end
      endcase
   end

   dpm_timer u_timer (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(tmr_load),
      .load_val(tmr_val),
      .done(tmr_done)
   );

   // State walks setup, settle, strobe, recover
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         op_r <= DPM_OP_READ;
      end else begin
         case (state_r)
            ST_IDLE: if (req_valid) begin
               state_r <= ST_SETUP;
               op_r <= req_op;
            end
            ST_SETUP: if (tmr_done) state_r <= ST_SETTLE;
            ST_SETTLE: if (tmr_load) state_r <= ST_STROBE; // Slave write waits [R22]
            ST_STROBE: if (tmr_done) state_r <= ST_RECOVER;
            ST_RECOVER: if (tmr_done) state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Address and write data held for the whole cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         addr <= '0;
         data_out <= '0;
      end else if (state_r == ST_IDLE && req_valid) begin
         addr <= req_addr; // Mailbox words at the top two addresses [R7] [R8]
         data_out <= req_wdata;
      end
   end

   // Control pins; only one select ever low [R21]
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         port_sel_n <= 1'b1;
         token_latch_select_n <= 1'b1;
         write_n <= 1'b1;
         out_en_n <= 1'b1;
         data_oe <= 1'b0;
      end else begin
         port_sel_n <= !(tmr_load && state_r == ST_SETTLE && !op_r[1]); // [R2] [R20]
         token_latch_select_n <= !(tmr_load && state_r == ST_SETTLE && op_r[1]); // [R6]
         write_n <= !(tmr_load && state_r == ST_SETTLE && is_write); // [R3]
         out_en_n <= !(tmr_load && state_r == ST_SETTLE && !is_write); // [R5]
         data_oe <= (state_r == ST_SETTLE && is_write) ||
                    (state_r == ST_STROBE && is_write && !tmr_done);
         if (state_r == ST_STROBE && !tmr_done) begin
            port_sel_n <= port_sel_n;
            token_latch_select_n <= token_latch_select_n;
            write_n <= write_n;
            out_en_n <= out_en_n;
         end
      end
   end

   // Read data captured at end of access, before strobes rise
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_r <= '0;
         rsp_valid_r <= 1'b0;
      end else begin
         rsp_valid_r <= (state_r == ST_STROBE) && tmr_done;
         if (state_r == ST_STROBE && tmr_done && !is_write) begin
            rd_data_r <= data_in; // Sampled after flow delay [R4]
         end
      end
   end
   assign rsp_valid = rsp_valid_r;
   assign rsp_rdata = rd_data_r;

   // Both selects low together must never occur
   a_select_excl: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(!port_sel_n && !token_latch_select_n)) else $error("both selects low"); // [R21]

   // Write strobe only inside a selected cycle
   a_write_window: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !write_n |-> (!port_sel_n || !token_latch_select_n)) else $error("stray write"); // [R3]

   // Read enable only with a select
   a_read_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !out_en_n |-> write_n && (!port_sel_n || !token_latch_select_n))
      else $error("read enable without select"); // [R5]

   // Write strobe lasts at least the minimum pulse
   a_write_width: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(write_n) |-> !write_n [*3]) else $error("write pulse too short"); // [R3]

   // Read held long enough for cross-port data
   a_read_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(out_en_n) |-> !out_en_n [*7]) else $error("read too short"); // [R4]

   // Slave never starts a write while contention is seen
   a_slave_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ($fell(write_n) && slave_mode) |-> !$past(busy_now)) else $error("slave write in contention"); // [R22]

   // Write starts only after settle phase
   a_settle_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(write_n) |-> $past(state_r) == ST_SETTLE) else $error("write before settle"); // [R19]

   // Released data lines when deselected in idle
   a_power_down: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (port_sel_n && token_latch_select_n && state_r == ST_IDLE) |-> !data_oe)
      else $error("driving while idle"); // [R20]
endmodule
`default_nettype wire

//--- dpm_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
// One port of the dual-port memory, as seen by its host
module dpm_dev_model (
   input wire logic port_sel_n,
   input wire logic tok_sel_n,
   input wire logic write_n,
   input wire logic out_en_n,
   input wire logic [dpm_pkg::ADDR_W-1:0] addr,
   input wire logic [dpm_pkg::DATA_W-1:0] wdata,
   input wire logic busy_n,
   input wire logic peer_wr,
   output logic [dpm_pkg::DATA_W-1:0] rdata,
   output logic contention_n,
   output logic irq_left_n,
   output logic irq_right_n
);
   import dpm_pkg::*;
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [7:0] tok = 8'hff;
   logic [DATA_W-1:0] last = '0;
   logic [ADDR_W-1:0] addr_d;
   logic [DATA_W-1:0] wdata_d;
   wire wr_on = !port_sel_n && !write_n;
   wire rd_on = !port_sel_n && !out_en_n && write_n;
   wire tok_wr = !tok_sel_n && !write_n;
   wire tok_rd = !tok_sel_n && !out_en_n && write_n;
   // Delayed copies give the pins a hold time past the strobe edge
   assign #1 addr_d = addr;
   assign #1 wdata_d = wdata;
   // Bench plays the arbiter: one result, master flag passed through
   assign contention_n = busy_n;
   initial begin
      irq_left_n = 1'b1;
      irq_right_n = 1'b1;
   end
   // Write ends at the first strobe to rise; busy low drops it
   always @(negedge wr_on) begin
      if (busy_n) begin
         mem[addr_d] = wdata_d;
         if (addr_d == MBOX_RIGHT) irq_right_n = 1'b0;
      end
   end
   always @(negedge tok_wr) tok[addr_d[2:0]] = wdata_d[0];
   // Far port writes the left mailbox
   always @(posedge peer_wr) irq_left_n = 1'b0;
   // Own mailbox read clears, unless busy; other reads leave it
   always @(negedge rd_on) begin
      if (busy_n && addr_d == MBOX_LEFT) irq_left_n = 1'b1;
   end
   // Lines released show no stale value
   always @(rd_on or tok_rd or addr or last) begin
      if (rd_on) rdata = mem.exists(addr) ? mem[addr] : '0;
      else if (tok_rd) rdata = {DATA_W{tok[addr[2:0]]}};
      else rdata = ~last;
   end
   always @(rdata) if (rd_on || tok_rd) last = rdata;
endmodule
`default_nettype wire

//--- test_dpm_host.sv
`timescale 1ns/100ps
`default_nettype none
module test_dpm_host;
   import dpm_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid = 1'b0, slave_mode = 1'b0, busy_n = 1'b1, peer_wr = 1'b0, got;
   dpm_op_t req_op = DPM_OP_READ;
   logic [ADDR_W-1:0] req_addr = '0, addr, a;
   logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_in, data_out, rd, d;
   logic req_ready, rsp_valid, irq_pending, port_sel_n, tok_sel_n, write_n, out_en_n;
   logic data_oe, contention_n, mailbox_irq_n, right_irq_n;
   logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
   int error_cnt = 0, total_checks = 0, cyc = 0;
   always #5 clk_sys = ~clk_sys;
   dpm_host u_dpm_host (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
      .slave_mode(slave_mode), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .irq_pending(irq_pending), .port_sel_n(port_sel_n), .token_latch_select_n(tok_sel_n),
      .write_n(write_n), .out_en_n(out_en_n), .addr(addr), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .contention_n(contention_n),
      .mailbox_irq_n(mailbox_irq_n));
   dpm_dev_model u_dpm_dev_model (.port_sel_n(port_sel_n), .tok_sel_n(tok_sel_n),
      .write_n(write_n), .out_en_n(out_en_n), .addr(addr), .wdata(data_out),
      .busy_n(busy_n), .peer_wr(peer_wr), .rdata(data_in), .contention_n(contention_n),
      .irq_left_n(mailbox_irq_n), .irq_right_n(right_irq_n));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Expected token read: latch value on every data line
   function automatic logic [DATA_W-1:0] tok_exp(input int v);
      return {DATA_W{v[0]}};
   endfunction
   task automatic end_sim();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Wait for the one-cycle answer, bounded
   task automatic wrsp(input int lim);
      got = 1'b0;
      for (int n = 0; n < lim && !got; n++) begin
         @(posedge clk_sys);
         #1;
         got = (rsp_valid === 1'b1);
      end
      rd = rsp_rdata;
   endtask
   task automatic acc(input dpm_op_t op, input logic [ADDR_W-1:0] aa,
      input logic [DATA_W-1:0] dd, input int lim);
      while (req_ready !== 1'b1) #1;
      @(posedge clk_sys);
      req_op <= op;
      req_addr <= aa;
      req_wdata <= dd;
      req_valid <= 1'b1;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      wrsp(lim);
   endtask
   task automatic settle();
      repeat (5) @(posedge clk_sys);
      #1;
   endtask
   // Pins checked mid-cycle, where they are settled
   always @(negedge clk_sys) begin
      if (port_sel_n === 1'b0) chk(tok_sel_n, 1'b1);
      if (write_n === 1'b0) chk(data_oe, 1'b1);
      if (out_en_n === 1'b0) chk(data_oe, 1'b0);
   end
   // Hang guard, well above the expected run
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(32'h9cc5));
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      // Idle levels right after release
      @(posedge clk_sys);
      #1;
      chk(req_ready, 1'b1);
      chk(port_sel_n, 1'b1);
      chk(data_oe, 1'b0);
      chk(irq_pending, 1'b0);
      // Random words plus both ends of the plain area
      for (int i = 0; i < 12; i++) begin
         a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1fffd : ADDR_W'($urandom_range(131069, 0));
         d = DATA_W'($urandom);
         acc(DPM_OP_WRITE, a, d, 40);
         chk(got, 1'b1);
         ref_mem[a] = d;
      end
      foreach (ref_mem[k]) begin
         acc(DPM_OP_READ, k, 9'h000, 40);
         chk(rd, ref_mem[k]);
      end
      // Mailbox traffic seen at the interrupt
      @(posedge clk_sys);
      peer_wr <= 1'b1;
      settle();
      chk(irq_pending, 1'b1);
      acc(DPM_OP_READ, MBOX_RIGHT, 9'h000, 40);
      settle();
      chk(irq_pending, 1'b1);
      @(posedge clk_sys);
      busy_n <= 1'b0;
      acc(DPM_OP_WRITE, MBOX_RIGHT, 9'h0a5, 40);
      chk(right_irq_n, 1'b1);
      acc(DPM_OP_READ, MBOX_LEFT, 9'h000, 40);
      settle();
      chk(irq_pending, 1'b1);
      @(posedge clk_sys);
      busy_n <= 1'b1;
      acc(DPM_OP_READ, MBOX_LEFT, 9'h000, 40);
      settle();
      chk(irq_pending, 1'b0);
      acc(DPM_OP_WRITE, MBOX_RIGHT, 9'h0a5, 40);
      chk(right_irq_n, 1'b0);
      // Slave write held while the flag is low
      @(posedge clk_sys);
      slave_mode <= 1'b1;
      busy_n <= 1'b0;
      acc(DPM_OP_WRITE, 17'h00123, 9'h155, 20);
      chk(got, 1'b0);
      @(posedge clk_sys);
      busy_n <= 1'b1;
      wrsp(40);
      chk(got, 1'b1);
      acc(DPM_OP_READ, 17'h00123, 9'h000, 40);
      chk(rd, 9'h155);
      // Token latch both values
      for (int v = 0; v < 2; v++) begin
         acc(DPM_OP_TOKEN_WR, 17'h00003, DATA_W'(v), 40);
         acc(DPM_OP_TOKEN_RD, 17'h00003, 9'h000, 40);
         chk(rd, tok_exp(v));
      end
      end_sim();
   end
endmodule
`default_nettype wire
